// [rtl/instr_exec_params.svh]
// timing counts, field positions and reset values of the executor
// assumes inclusion from the package, the executor, the partner and the bench
`ifndef INSTR_EXEC_PARAMS_SVH
`define INSTR_EXEC_PARAMS_SVH
`define IW_WIDTH 14
`define Q_PER_CYCLE 3'h4
`define OP_LIT_ADD 4'hE
`define OP_LIT_AND 4'h9
`define OP_LIT_LOAD 4'h0
`define OP_ADD_F 4'h7
`define OP_AND_F 4'h5
`define OP_OR_F 4'h4
`define OP_COPY_F 4'h8
`define OP_RR_F 4'hC
`define OP_RL_F 4'hD
`define IW_RETURN 14'h0008
`define IW_SLEEP 14'h0063
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_SLEEP 3
`define ST_TIMEOUT 4
`define STATUS_RST 8'h18
`define PC_RST 13'h0000
`define STACK_DEPTH 8
`define REG_ACC_OFS 12'h000
`define REG_STATUS_OFS 12'h004
`define REG_INSTR_OFS 12'h008
`define REG_PC_OFS 12'h00C
`define REG_CTRL_OFS 12'h010
`endif

// [rtl/instr_exec_pkg.sv]
// types shared by the executor
// assumes instr_exec_params.svh is on the include path
package instr_exec_pkg;
`include "instr_exec_params.svh"
   typedef enum logic [1:0] {EX_RUN, EX_FLUSH, EX_SLEEP} exec_state_t;
endpackage

// [rtl/instr_exec.sv]
// decode and execute of a subset of the 14-bit instruction set
// assumes program memory and file are outside, answering combinationally
//
// Our own choices: the APB register port and the address map.
`include "instr_exec_params.svh"

// Behaviour
// RULE1 - literal add into accumulator, arithmetic flags
// RULE2 - literal AND into accumulator, zero flag
// RULE3 - add accumulator to file register, flags
// RULE4 - destination bit picks accumulator or file
// RULE5 - AND accumulator with file, zero flag
// RULE6 - OR accumulator with file, zero flag
// RULE7 - copy file, zero flag set from value
// RULE8 - literal load, flags unchanged
// RULE9 - return pops stack, two cycles
// RULE10 - rotate right through carry
// RULE11 - rotate left through carry
// RULE12 - sleep clears watchdog, sets timeout, stops
// RULE13 - carry bit7, nibble bit3, zero result
// RULE14 - instruction word is fourteen bits
// RULE15 - pc change costs two cycles, second nop
// RULE16 - instruction cycle is four clock periods
module instr_exec (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // program memory
   output logic [12:0] prog_addr,
   input wire logic [13:0] prog_word,
   // data register file
   output logic [6:0] file_addr,
   input wire logic [7:0] file_rdata,
   output logic [7:0] file_wdata,
   output logic file_we,
   // watchdog and oscillator
   output logic wdt_clear,
   output logic osc_stop,
   input wire logic wake_req,
   // subroutine stack push from the wider core
   input wire logic call_push,
   input wire logic [12:0] call_target
);
   //==========================================================
   // state
   instr_exec_pkg::exec_state_t state_r;
   logic [1:0] q_r;
   logic [12:0] pc_r;
   logic [13:0] ir_r;
   logic [7:0] acc_r;
   logic [7:0] status_r;
   logic [12:0] stack_r [`STACK_DEPTH];
   logic [2:0] sp_r;
   logic run_r;
   logic wake_s1_r;
   logic wake_s2_r;
   logic [13:0] prog_s1_r;
   logic [13:0] prog_s2_r;
   logic [7:0] fd_s1_r;
   logic [7:0] fd_s2_r;
   logic [7:0] opnd_r;

   //==========================================================
   // decode helpers
   function automatic logic [8:0] add9(input logic [7:0] a,
                                       input logic [7:0] b);
      add9 = {1'b0, a} + {1'b0, b};
   endfunction

   function automatic logic nib_carry(input logic [7:0] a,
                                      input logic [7:0] b);
      logic [4:0] s;
      s = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      nib_carry = s[4];
   endfunction

   // RULE14 fourteen bit word
   logic [1:0] grp;
   logic [3:0] op;
   logic dest;
   logic [7:0] lit;
   assign grp = ir_r[13:12];
   assign op = ir_r[11:8];
   assign dest = ir_r[7];
   assign lit = ir_r[7:0];

   //==========================================================
   // instruction cycle phases
   // RULE16 four phases a cycle
   logic last_q;
   assign last_q = (q_r == 2'(`Q_PER_CYCLE - 3'h1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= 2'h0;
      end else if (state_r == instr_exec_pkg::EX_SLEEP || !run_r) begin
         q_r <= 2'h0;
      end else begin
         q_r <= q_r + 2'h1;
      end
   end

   // wake, program word and file data inputs are synchronised before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         prog_s1_r <= 14'h0000;
         prog_s2_r <= 14'h0000;
         fd_s1_r <= 8'h00;
         fd_s2_r <= 8'h00;
      end else begin
         wake_s1_r <= wake_req;
         wake_s2_r <= wake_s1_r;
         prog_s1_r <= prog_word;
         prog_s2_r <= prog_s1_r;
         fd_s1_r <= file_rdata;
         fd_s2_r <= fd_s1_r;
      end
   end

   // operand taken straight from the second stage: a registered copy
   // taken at phase 2 would still hold the previous address's data
   always_comb begin
      opnd_r = fd_s2_r;
   end

   //==========================================================
   // execute
   logic [7:0] res;
   logic [7:0] st_nxt;
   logic wr_acc;
   logic wr_file;
   logic do_ret;
   logic do_sleep;
   logic [8:0] sum;

   always_comb begin
      res = 8'h00;
      st_nxt = status_r;
      wr_acc = 1'b0;
      wr_file = 1'b0;
      do_ret = 1'b0;
      do_sleep = 1'b0;
      sum = 9'h000;
      if (grp == 2'h3) begin
         if (op[3:1] == `OP_LIT_ADD >> 1) begin
            // RULE1 literal add
            sum = add9(acc_r, lit);
            res = sum[7:0];
            wr_acc = 1'b1;
            // RULE13 carry nibble zero
            st_nxt[`ST_CARRY] = sum[8];
            st_nxt[`ST_NIBBLE] = nib_carry(acc_r, lit);
            st_nxt[`ST_ZERO] = (sum[7:0] == 8'h00);
         end else if (op == `OP_LIT_AND) begin
            // RULE2 literal and
            res = acc_r & lit;
            wr_acc = 1'b1;
            st_nxt[`ST_ZERO] = (res == 8'h00);
         end else if (op[3:2] == `OP_LIT_LOAD >> 2) begin
            // RULE8 load, flags kept
            res = lit;
            wr_acc = 1'b1;
         end
      end else if (grp == 2'h0) begin
         if (ir_r == `IW_RETURN) begin
            // RULE9 pop stack
            do_ret = 1'b1;
         end else if (ir_r == `IW_SLEEP) begin
            // RULE12 power down
            do_sleep = 1'b1;
            st_nxt[`ST_TIMEOUT] = 1'b1;
            st_nxt[`ST_SLEEP] = 1'b0;
         end else begin
            case (op)
               `OP_ADD_F: begin
                  // RULE3 file add
                  sum = add9(acc_r, opnd_r);
                  res = sum[7:0];
                  st_nxt[`ST_CARRY] = sum[8];
                  st_nxt[`ST_NIBBLE] = nib_carry(acc_r, opnd_r);
                  st_nxt[`ST_ZERO] = (sum[7:0] == 8'h00);
               end
               `OP_AND_F: begin
                  // RULE5 file and
                  res = acc_r & opnd_r;
                  st_nxt[`ST_ZERO] = (res == 8'h00);
               end
               `OP_OR_F: begin
                  // RULE6 file or
                  res = acc_r | opnd_r;
                  st_nxt[`ST_ZERO] = (res == 8'h00);
               end
               `OP_COPY_F: begin
                  // RULE7 copy as test
                  res = opnd_r;
                  st_nxt[`ST_ZERO] = (res == 8'h00);
               end
               `OP_RR_F: begin
                  // RULE10 rotate right
                  res = {status_r[`ST_CARRY], opnd_r[7:1]};
                  st_nxt[`ST_CARRY] = opnd_r[0];
               end
               `OP_RL_F: begin
                  // RULE11 rotate left
                  res = {opnd_r[6:0], status_r[`ST_CARRY]};
                  st_nxt[`ST_CARRY] = opnd_r[7];
               end
               default: begin
                  res = 8'h00;
               end
            endcase
            if (op == `OP_ADD_F || op == `OP_AND_F || op == `OP_OR_F ||
                op == `OP_COPY_F || op == `OP_RR_F || op == `OP_RL_F) begin
               // RULE4 destination select
               wr_acc = !dest;
               wr_file = dest;
            end
         end
      end
   end

   logic exec_now;
   assign exec_now = last_q && run_r && state_r == instr_exec_pkg::EX_RUN;

   // RULE15 flush after pc change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= instr_exec_pkg::EX_RUN;
      end else begin
         case (state_r)
            instr_exec_pkg::EX_RUN: begin
               if (exec_now && do_ret) begin
                  state_r <= instr_exec_pkg::EX_FLUSH;
               end else if (exec_now && do_sleep) begin
                  state_r <= instr_exec_pkg::EX_SLEEP;
               end
            end
            instr_exec_pkg::EX_FLUSH: begin
               if (last_q) begin
                  state_r <= instr_exec_pkg::EX_RUN;
               end
            end
            instr_exec_pkg::EX_SLEEP: begin
               if (wake_s2_r) begin
                  state_r <= instr_exec_pkg::EX_RUN;
               end
            end
            default: begin
               state_r <= instr_exec_pkg::EX_RUN;
            end
         endcase
      end
   end

   // fetch: the word is latched at the end of each cycle, except a return cycle, which latches a nop in its place
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_r <= 14'h0000;
      end else if (last_q && run_r) begin
         ir_r <= (exec_now && do_ret) ? 14'h0000 : prog_s2_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= `PC_RST;
         sp_r <= 3'h0;
      end else if (exec_now && do_ret) begin
         // RULE9 stack head to pc
         pc_r <= stack_r[sp_r - 3'h1];
         sp_r <= sp_r - 3'h1;
      end else if (call_push) begin
         sp_r <= sp_r + 3'h1;
      end else if (last_q && run_r) begin
         pc_r <= pc_r + 13'h0001;
      end
   end

   always_ff @(posedge pclk) begin
      if (call_push) begin
         stack_r[sp_r] <= call_target;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= 8'h00;
         status_r <= `STATUS_RST;
      end else if (psel && penable && pwrite && paddr == `REG_ACC_OFS) begin
         acc_r <= pwdata[7:0];
      end else if (exec_now) begin
         if (wr_acc) begin
            acc_r <= res;
         end
         status_r <= st_nxt;
      end
   end

   // file write and outward strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_we <= 1'b0;
         file_wdata <= 8'h00;
         file_addr <= 7'h00;
         prog_addr <= `PC_RST;
         wdt_clear <= 1'b0;
         osc_stop <= 1'b0;
      end else begin
         file_we <= exec_now && wr_file;
         file_wdata <= res;
         file_addr <= ir_r[6:0];
         prog_addr <= pc_r;
         // RULE12 clear watchdog, stop oscillator
         wdt_clear <= exec_now && do_sleep;
         osc_stop <= (state_r == instr_exec_pkg::EX_SLEEP) && !wake_s2_r;
      end
   end

   //==========================================================
   // apb registers, one wait-free access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
      end else if (psel && penable && pwrite && paddr == `REG_CTRL_OFS) begin
         run_r <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel && !penable) begin
            case (paddr)
               `REG_ACC_OFS: prdata <= {24'h000000, acc_r};
               `REG_STATUS_OFS: prdata <= {24'h000000, status_r};
               `REG_INSTR_OFS: prdata <= {18'h00000, ir_r};
               `REG_PC_OFS: prdata <= {19'h00000, pc_r};
               `REG_CTRL_OFS: prdata <= {31'h00000000, run_r};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// [test/instr_exec_monitor.sv]
// port checker for the instruction executor
// assumes one clock domain, bound onto every instr_exec
module instr_exec_monitor (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // apb
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   // core side
   input logic [12:0] prog_addr,
   input logic file_we,
   input logic wdt_clear,
   input logic osc_stop,
   input logic wake_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // properties
   a_pc_four_clocks: assert property (
      $changed(prog_addr) |=> $stable(prog_addr) [*3])
      else $error("pc moved inside an instruction cycle");
   a_we_spacing: assert property (
      file_we |=> !file_we [*3]) else $error("file write too soon");
   a_stop_holds: assert property (
      (!wake_req) [*4] ##0 osc_stop |=> osc_stop)
      else $error("sleep left without wake");
   a_sleep_frozen: assert property (
      osc_stop [*3] |-> $stable(prog_addr)) else $error("fetch in sleep");
   a_wdt_on_sleep: assert property ($rose(osc_stop) |->
      wdt_clear || $past(wdt_clear) || $past(wdt_clear, 2))
      else $error("sleep without watchdog clear");
   a_we_awake: assert property (
      file_we |-> !osc_stop) else $error("file write while asleep");
   a_setup_ready: assert property (
      psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_pulse: assert property (
      pready |=> !pready) else $error("ready longer than a cycle");
   a_err_ready: assert property (
      pslverr |-> pready) else $error("error without ready");
   cover property (file_we);
   cover property ($rose(osc_stop));
   cover property (pslverr);
endmodule

bind instr_exec instr_exec_monitor mon (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .prog_addr, .file_we, .wdt_clear, .osc_stop,
   .wake_req);

// [test/instr_exec_partner.sv]
// program memory and data register file beside the executor
// assumes the bench preloads both arrays by hierarchy
`include "instr_exec_params.svh"
module instr_exec_partner (
   // clock
   input logic pclk,
   // program memory
   input logic [12:0] prog_addr,
   output logic [13:0] prog_word,
   // data register file
   input logic [6:0] file_addr,
   output logic [7:0] file_rdata,
   input logic [7:0] file_wdata,
   input logic file_we
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] rom [256];
   logic [7:0] ram [128];
   // blank words sleep so a runaway pc halts instead of corrupting state
   initial foreach (rom[i]) rom[i] = `IW_SLEEP;
   assign prog_word = rom[prog_addr[7:0]];
   assign file_rdata = ram[file_addr];
   always @(posedge pclk) begin
      if (file_we) ram[file_addr] <= file_wdata;
   end
endmodule

// [test/mcu_instr_exec_subset_tb_top.sv]
// self-checking bench: short programs, results read over apb
// assumes instr_exec_params.svh on the include path
`include "instr_exec_params.svh"
module mcu_instr_exec_subset_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [13:0] S = `IW_SLEEP;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, wake_req = 1'h0, call_push = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q, ra, rs;
   logic pready, pslverr, e, file_we, wdt_clear, osc_stop;
   logic [12:0] prog_addr, call_target = 13'h0;
   logic [13:0] prog_word;
   logic [6:0] file_addr;
   logic [7:0] file_rdata, file_wdata;
   int err_total = 0, compares = 0;
   always #2 pclk = ~pclk;
   instr_exec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .prog_addr, .prog_word,
      .file_addr, .file_rdata, .file_wdata, .file_we, .wdt_clear,
      .osc_stop, .wake_req, .call_push, .call_target);
   instr_exec_partner part (.pclk, .prog_addr, .prog_word, .file_addr,
      .file_rdata, .file_wdata, .file_we);
   // ==========================================
   // tasks
   task print_verdict;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, x);
      compares++;
      if (s !== x) begin
         err_total++;
         $display("BAD %s exp %h seen %h", n, x, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rst;
      presetn <= 1'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
   endtask
   function logic [13:0] bo(input logic [3:0] o, input logic d,
      input logic [6:0] f);
      return {2'h0, o, d, f};
   endfunction
   // one program from reset until it sleeps, then fetch acc and status
   task run(input logic [7:0] a0, input logic [13:0] p [8],
      input logic [12:0] t);
      rst;
      for (int i = 0; i < 8; i++) part.rom[i] = p[i];
      apb(1'h1, `REG_ACC_OFS, {24'h0, a0});
      if (t !== 13'h0) begin
         call_push <= 1'h1;
         call_target <= t;
         @(posedge pclk);
         call_push <= 1'h0;
      end
      apb(1'h1, `REG_CTRL_OFS, 32'h1);
      for (int n = 0; n < 400 && osc_stop !== 1'h1; n++) @(posedge pclk);
      chk("osc_stop", 32'(osc_stop), 32'h1);
      apb(1'h0, `REG_ACC_OFS, 32'h0);
      ra = q;
      apb(1'h0, `REG_STATUS_OFS, 32'h0);
      rs = q;
   endtask
   // ==========================================
   // watchdog
   initial begin
      #40000;
      err_total++;
      print_verdict;
   end
   // ==========================================
   // tests
   initial begin
      rst;
      apb(1'h0, `REG_PC_OFS, 32'h0);
      chk("pc", q, 32'h0);
      apb(1'h1, `REG_STATUS_OFS, 32'h0);
      apb(1'h0, `REG_STATUS_OFS, 32'h0);
      chk("status", q, 32'h18);
      apb(1'h0, 12'hF00, 32'h0);
      chk("slverr", 32'(e), 32'h1);
      run(8'h0, '{{6'h30, 8'h10}, {6'h3E, 8'h15}, S, S, S, S, S, S}, 13'h0);
      chk("acc", ra, 32'h25);
      chk("status", rs, 32'h10);
      run(8'h0, '{{6'h30, 8'h88}, {6'h3E, 8'h78}, {6'h33, 8'h5A}, S, S,
         S, S, S}, 13'h0);
      chk("acc", ra, 32'h5A);
      chk("status", rs, 32'h17);
      run(8'h0, '{{6'h30, 8'h01}, {6'h3E, 8'hFF}, {6'h39, 8'h5F},
         {6'h30, 8'hA3}, {6'h39, 8'h5F}, S, S, S}, 13'h0);
      chk("acc", ra, 32'h03);
      chk("status", rs, 32'h13);
      part.ram[7'h20] = 8'hC2;
      part.ram[7'h7F] = 8'h01;
      part.ram[7'h21] = 8'hC2;
      part.ram[7'h22] = 8'h13;
      part.ram[7'h23] = 8'h00;
      run(8'h0, '{{6'h30, 8'h17}, bo(`OP_ADD_F, 1'h0, 7'h20),
         bo(`OP_ADD_F, 1'h1, 7'h7F), bo(`OP_AND_F, 1'h1, 7'h21),
         bo(`OP_OR_F, 1'h0, 7'h22), bo(`OP_COPY_F, 1'h1, 7'h23), S, S},
         13'h0);
      chk("acc", ra, 32'hDB);
      chk("status", rs, 32'h14);
      chk("f20", 32'(part.ram[7'h20]), 32'hC2);
      chk("f7f", 32'(part.ram[7'h7F]), 32'hDA);
      chk("f21", 32'(part.ram[7'h21]), 32'hC0);
      chk("f23", 32'(part.ram[7'h23]), 32'h00);
      part.ram[7'h30] = 8'hE6;
      part.ram[7'h31] = 8'hE6;
      run(8'h0, '{{6'h30, 8'hFF}, {6'h3E, 8'h01}, bo(`OP_RR_F, 1'h0, 7'h30),
         bo(`OP_RL_F, 1'h1, 7'h31), S, S, S, S}, 13'h0);
      chk("acc", ra, 32'hF3);
      chk("status", rs, 32'h17);
      chk("f30", 32'(part.ram[7'h30]), 32'hE6);
      chk("f31", 32'(part.ram[7'h31]), 32'hCC);
      part.rom[16] = {6'h30, 8'h42};
      run(8'h77, '{`IW_RETURN, {6'h30, 8'h99}, S, S, S, S, S, S}, 13'h10);
      chk("acc", ra, 32'h42);
      chk("status", rs, 32'h10);
      wake_req <= 1'h1;
      for (int n = 0; n < 40 && osc_stop !== 1'h0; n++) @(posedge pclk);
      chk("wake", 32'(osc_stop), 32'h0);
      wake_req <= 1'h0;
      print_verdict;
   end
endmodule
